/* core/spwf_defs.svh */
`ifndef SPWF_DEFS_SVH
`define SPWF_DEFS_SVH
// How it works
// - Streaming applies to posted writes only
// - Base window picks streaming versus storage
// - Upper address picks stream, low bits segment; the code uses the whole address as the stream id
// - Short message goes as one write
// - Long message splits into 64-byte segments
// - Last word padded, data in low bytes
// - One source per stream keeps order
// - Command is posted write, word length
// - Word count all ones except last segment
// - Byte count is last word bytes minus one
// - Without end: 00 data, 01 abort
// - After abort drop stream until start flag
// - End flag only on final segment
// - Start flag only on first segment
// - Layout select bit zero means streaming
// - Address bits form the stream identifier
// - Middle hops route as plain posted writes
// - Requested channel names channel in set two
// - Eight bit-time header with fixed field layout
// - Payload follows its header immediately
// - Fixed maximum size, smaller one configurable
// - Count aborts, too-long messages, other errors

// Register byte offsets
`define SPWF_OFS_CTRL 8'h00
`define SPWF_OFS_WBASE 8'h04
`define SPWF_OFS_WMASK 8'h08
`define SPWF_OFS_MAXSZ 8'h0c
`define SPWF_OFS_ABCNT 8'h10
`define SPWF_OFS_TLCNT 8'h14
`define SPWF_OFS_ERCNT 8'h18
`define SPWF_OFS_STAT 8'h1c
// Control field positions
`define SPWF_CTRL_COH 0
`define SPWF_CTRL_ISOC 1
`define SPWF_CTRL_PPW 2
`define SPWF_CTRL_CHSET 3
`define SPWF_CTRL_VC_LO 4
`define SPWF_CTRL_UNIT_LO 8
// Reset values
`define SPWF_CTRL_RST 32'h0000_0000
`define SPWF_WBASE_RST 32'h0000_0000
`define SPWF_WMASK_RST 32'hffff_ff00
// Encodings and counts
`define SPWF_CMD_PW 4'hb
`define SPWF_SEG_BYTES 16'h0040
`define SPWF_BC_VALID 2'h0
`define SPWF_BC_ABORT 2'h1
`define SPWF_HDR_LAST 3'h7
`endif

/* core/spwf_pkg.sv */
package spwf_pkg;
  typedef enum logic [1:0] {st_tx_idle, st_tx_hdr, st_tx_data} spwf_tx_st_t;
  typedef enum logic {st_rx_hdr, st_rx_data} spwf_rx_st_t;
endpackage

/* core/spwf_framer.sv */
`include "spwf_defs.svh"
module spwf_framer import spwf_pkg::*; #(
  parameter logic [15:0] MAX_MSG = 16'h1000,
  parameter int NSB = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Outgoing messages
  input wire logic tx_start,
  input wire logic tx_abort,
  input wire logic [15:0] tx_len,
  input wire logic [31:0] tx_stream,
  input wire logic [31:0] tx_word,
  output logic tx_word_rd,
  output logic tx_busy,
  // Link transmit bit-times
  output logic lk_tx_vld,
  output logic lk_tx_ctl,
  output logic [7:0] lk_tx_dat,
  // Link receive bit-times
  input wire logic lk_rx_vld,
  input wire logic lk_rx_ctl,
  input wire logic [7:0] lk_rx_dat,
  // Reassembled messages
  output logic rx_vld,
  output logic [31:0] rx_word,
  output logic [31:0] rx_stream,
  output logic rx_first,
  output logic rx_last,
  output logic [1:0] rx_nbytes,
  output logic rx_abort
);
  localparam int NS = 1 << NSB;

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [3:0] spwf_seg_cnt(input logic [15:0] rem);
    logic [15:0] w;
    w = (rem + 16'h0003) >> 2;
    if (rem >= `SPWF_SEG_BYTES) begin
      return 4'hf;
    end
    return 4'(w - 16'h0001);
  endfunction

  function automatic logic [15:0] spwf_seg_bytes(input logic [3:0] cnt, input logic fin, input logic [1:0] bc);
    logic [15:0] base;
    base = {10'h000, cnt, 2'b00};
    return fin ? base + {14'h0000, bc} + 16'h0001 : base + 16'h0004;
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] ctrl_ff, wbase_ff, wmask_ff, rdata_ff;
  logic [31:0] nxt_ctrl, nxt_wbase, nxt_wmask, nxt_rdata;
  logic [15:0] maxsz_ff, nxt_maxsz;
  logic [15:0] abcnt_ff, tlcnt_ff, ercnt_ff;
  logic [15:0] nxt_abcnt, nxt_tlcnt, nxt_ercnt;
  spwf_tx_st_t tx_st_ff, nxt_tx_st;
  spwf_rx_st_t rx_st_ff, nxt_rx_st;

  // Write decode and read mux, data one cycle after the strobe
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_wbase = wbase_ff;
    nxt_wmask = wmask_ff;
    nxt_maxsz = maxsz_ff;
    nxt_rdata = 32'h0000_0000;
    if (reg_wr) begin
      unique case (reg_addr)
        `SPWF_OFS_CTRL: nxt_ctrl = reg_wdata;
        `SPWF_OFS_WBASE: nxt_wbase = reg_wdata;
        `SPWF_OFS_WMASK: nxt_wmask = reg_wdata;
        // Clamped so software can only lower the hardware maximum
        `SPWF_OFS_MAXSZ: nxt_maxsz = (reg_wdata > {16'h0000, MAX_MSG}) ? MAX_MSG : reg_wdata[15:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `SPWF_OFS_CTRL: nxt_rdata = ctrl_ff;
        `SPWF_OFS_WBASE: nxt_rdata = wbase_ff;
        `SPWF_OFS_WMASK: nxt_rdata = wmask_ff;
        `SPWF_OFS_MAXSZ: nxt_rdata = {16'h0000, maxsz_ff};
        `SPWF_OFS_ABCNT: nxt_rdata = {16'h0000, abcnt_ff};
        `SPWF_OFS_TLCNT: nxt_rdata = {16'h0000, tlcnt_ff};
        `SPWF_OFS_ERCNT: nxt_rdata = {16'h0000, ercnt_ff};
        `SPWF_OFS_STAT: nxt_rdata = {30'h0000_0000, rx_st_ff == st_rx_data, tx_st_ff != st_tx_idle};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= `SPWF_CTRL_RST;
      wbase_ff <= `SPWF_WBASE_RST;
      wmask_ff <= `SPWF_WMASK_RST;
      maxsz_ff <= MAX_MSG;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ctrl_ff <= nxt_ctrl;
      wbase_ff <= nxt_wbase;
      wmask_ff <= nxt_wmask;
      maxsz_ff <= nxt_maxsz;
      rdata_ff <= nxt_rdata;
    end
  end
  assign reg_rdata = rdata_ff;

  // ****************************************
  // Segmenting transmitter
  // ****************************************
  logic [15:0] rem_ff, nxt_rem;
  logic [31:0] strm_ff, nxt_strm, word_ff, nxt_word;
  logic [2:0] bt_ff, nxt_bt;
  logic [3:0] wcnt_ff, nxt_wcnt;
  logic [1:0] byte_ff, nxt_byte;
  logic first_ff, nxt_first, abort_ff, nxt_abort;
  logic rd_ff, nxt_rd, lvld_ff, nxt_lvld, lctl_ff, nxt_lctl, busy_ff, nxt_busy;
  logic [7:0] ldat_ff, nxt_ldat;
  logic [3:0] cnt_c, vc_c;
  logic last_c, fin_c;
  logic [1:0] bc_c;
  logic [7:0] hb_c, db_c;
  logic [31:0] wsrc_c;

  // Header fields are derived from the bytes still to send
  always_comb begin
    cnt_c = abort_ff ? 4'h0 : spwf_seg_cnt(rem_ff);
    last_c = abort_ff || (rem_ff <= `SPWF_SEG_BYTES);
    fin_c = last_c && !abort_ff;
    bc_c = abort_ff ? `SPWF_BC_ABORT : (fin_c ? 2'(rem_ff - 16'h0001) : `SPWF_BC_VALID);
    vc_c = ctrl_ff[`SPWF_CTRL_CHSET] ? ctrl_ff[`SPWF_CTRL_VC_LO +: 4] : 4'h0;
    unique case (bt_ff)
      3'h0: hb_c = {2'b00, `SPWF_CMD_PW, ctrl_ff[`SPWF_CTRL_ISOC], ctrl_ff[`SPWF_CTRL_COH]};
      3'h1: hb_c = {ctrl_ff[`SPWF_CTRL_PPW], 1'b0, vc_c[3], ctrl_ff[`SPWF_CTRL_UNIT_LO +: 5]};
      3'h2: hb_c = {cnt_c[1:0], 3'b000, vc_c[2:0]};
      3'h3: hb_c = {first_ff, fin_c, 1'b0, 1'b0, bc_c, cnt_c[3:2]};
      3'h4: hb_c = strm_ff[7:0];
      3'h5: hb_c = strm_ff[15:8];
      3'h6: hb_c = strm_ff[23:16];
      3'h7: hb_c = strm_ff[31:24];
    endcase
    // Word arrives the cycle after the fetch pulse, just as byte 0 is due
    wsrc_c = (byte_ff != 2'h0) ? word_ff : (abort_ff ? 32'h0000_0000 : tx_word);
    db_c = wsrc_c[{byte_ff, 3'b000} +: 8];
    if (last_c && wcnt_ff == 4'h0 && byte_ff > bc_c && fin_c) begin
      db_c = 8'h00;
    end
  end

  // Transmit sequencing: header, then its data right behind it
  always_comb begin
    nxt_tx_st = tx_st_ff;
    nxt_rem = rem_ff;
    nxt_strm = strm_ff;
    nxt_word = word_ff;
    nxt_bt = bt_ff;
    nxt_wcnt = wcnt_ff;
    nxt_byte = byte_ff;
    nxt_first = first_ff;
    nxt_abort = abort_ff;
    nxt_rd = 1'b0;
    unique case (tx_st_ff)
      st_tx_idle: begin
        // Zero length requests are ignored unless tx_abort is set; a busy framer ignores starts
        if (tx_start && (tx_len != 16'h0000 || tx_abort)) begin
          nxt_tx_st = st_tx_hdr;
          nxt_rem = tx_len;
          nxt_strm = tx_stream;
          nxt_first = !tx_abort;
          nxt_abort = tx_abort;
          nxt_bt = 3'h0;
        end
      end
      st_tx_hdr: begin
        nxt_bt = bt_ff + 3'h1;
        nxt_rd = (bt_ff == 3'h6) && !abort_ff;
        if (bt_ff == `SPWF_HDR_LAST) begin
          nxt_tx_st = st_tx_data;
          nxt_wcnt = cnt_c;
          nxt_byte = 2'h0;
        end
      end
      st_tx_data: begin
        nxt_byte = byte_ff + 2'h1;
        if (byte_ff == 2'h0) begin
          nxt_word = wsrc_c;
        end
        nxt_rd = (byte_ff == 2'h2) && (wcnt_ff != 4'h0) && !abort_ff;
        if (byte_ff == 2'h3) begin
          nxt_wcnt = wcnt_ff - 4'h1;
          if (wcnt_ff == 4'h0) begin
            nxt_bt = 3'h0;
            nxt_first = 1'b0;
            nxt_rem = rem_ff - `SPWF_SEG_BYTES;
            nxt_tx_st = last_c ? st_tx_idle : st_tx_hdr;
          end
        end
      end
      default: nxt_tx_st = st_tx_idle;
    endcase
    nxt_lvld = (tx_st_ff != st_tx_idle);
    nxt_lctl = (tx_st_ff == st_tx_hdr);
    nxt_busy = (nxt_tx_st != st_tx_idle);
    nxt_ldat = (tx_st_ff == st_tx_hdr) ? hb_c : ((tx_st_ff == st_tx_data) ? db_c : 8'h00);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_st_ff <= st_tx_idle;
      rem_ff <= 16'h0000;
      strm_ff <= 32'h0000_0000;
      word_ff <= 32'h0000_0000;
      bt_ff <= 3'h0;
      wcnt_ff <= 4'h0;
      byte_ff <= 2'h0;
      first_ff <= 1'b0;
      abort_ff <= 1'b0;
      rd_ff <= 1'b0;
      busy_ff <= 1'b0;
      lvld_ff <= 1'b0;
      lctl_ff <= 1'b0;
      ldat_ff <= 8'h00;
    end else begin
      tx_st_ff <= nxt_tx_st;
      rem_ff <= nxt_rem;
      strm_ff <= nxt_strm;
      word_ff <= nxt_word;
      bt_ff <= nxt_bt;
      wcnt_ff <= nxt_wcnt;
      byte_ff <= nxt_byte;
      first_ff <= nxt_first;
      abort_ff <= nxt_abort;
      rd_ff <= nxt_rd;
      busy_ff <= nxt_busy;
      lvld_ff <= nxt_lvld;
      lctl_ff <= nxt_lctl;
      ldat_ff <= nxt_ldat;
    end
  end
  assign tx_word_rd = rd_ff;
  assign tx_busy = busy_ff;
  assign lk_tx_vld = lvld_ff;
  assign lk_tx_ctl = lctl_ff;
  assign lk_tx_dat = ldat_ff;

  // ****************************************
  // Reassembling receiver
  // ****************************************
  logic [2:0] rbt_ff, nxt_rbt;
  logic [5:0] rcmd_ff, nxt_rcmd;
  logic [3:0] rcnt_ff, nxt_rcnt, rwl_ff, nxt_rwl;
  logic rsom_ff, nxt_rsom, reom_ff, nxt_reom, rfmt_ff, nxt_rfmt;
  logic [1:0] rbc_ff, nxt_rbc, rbyte_ff, nxt_rbyte;
  logic [23:0] raddr_ff, nxt_raddr, racc_ff, nxt_racc;
  logic keep_ff, nxt_keep, rfirst_ff, nxt_rfirst;
  logic [NS-1:0] disc_ff, nxt_disc;
  logic [15:0] len_ff [NS];
  logic [15:0] nxt_len [NS];
  logic ovld_ff, nxt_ovld, ofst_ff, nxt_ofst, olst_ff, nxt_olst, oab_ff, nxt_oab;
  logic [31:0] oword_ff, nxt_oword, ostrm_ff, nxt_ostrm;
  logic [1:0] onb_ff, nxt_onb;
  logic [31:0] strm_c;
  logic [NSB-1:0] idx_c;
  logic [15:0] newlen_c;
  logic is_str_c, drop_c, ab_ev, tl_ev, er_ev;

  // Header decode at the eighth bit-time, data assembled into words
  always_comb begin
    nxt_rx_st = rx_st_ff;
    nxt_rbt = rbt_ff;
    nxt_rcmd = rcmd_ff;
    nxt_rcnt = rcnt_ff;
    nxt_rwl = rwl_ff;
    nxt_rsom = rsom_ff;
    nxt_reom = reom_ff;
    nxt_rfmt = rfmt_ff;
    nxt_rbc = rbc_ff;
    nxt_rbyte = rbyte_ff;
    nxt_raddr = raddr_ff;
    nxt_racc = racc_ff;
    nxt_keep = keep_ff;
    nxt_rfirst = rfirst_ff;
    nxt_disc = disc_ff;
    nxt_len = len_ff;
    nxt_ostrm = ostrm_ff;
    nxt_oword = oword_ff;
    nxt_ofst = ofst_ff;
    nxt_olst = olst_ff;
    nxt_onb = onb_ff;
    nxt_ovld = 1'b0;
    nxt_oab = 1'b0;
    strm_c = {lk_rx_dat, raddr_ff};
    idx_c = strm_c[NSB-1:0];
    is_str_c = (rcmd_ff[5:2] == `SPWF_CMD_PW) && (((strm_c ^ wbase_ff) & wmask_ff) == 32'h0000_0000)
      && !rfmt_ff;
    drop_c = disc_ff[idx_c] && !rsom_ff;
    newlen_c = (rsom_ff ? 16'h0000 : len_ff[idx_c]) + spwf_seg_bytes(rcnt_ff, reom_ff, rbc_ff);
    ab_ev = 1'b0;
    tl_ev = 1'b0;
    er_ev = 1'b0;
    if (lk_rx_vld && lk_rx_ctl) begin
      nxt_rbt = rbt_ff + 3'h1;
      nxt_rx_st = st_rx_hdr;
      unique case (rbt_ff)
        3'h0: nxt_rcmd = lk_rx_dat[5:0];
        3'h2: nxt_rcnt[1:0] = lk_rx_dat[7:6];
        3'h3: {nxt_rsom, nxt_reom, nxt_rfmt, nxt_rbc, nxt_rcnt[3:2]} =
          {lk_rx_dat[7:6], lk_rx_dat[4:0]};
        3'h4: nxt_raddr[7:0] = lk_rx_dat;
        3'h5: nxt_raddr[15:8] = lk_rx_dat;
        3'h6: nxt_raddr[23:16] = lk_rx_dat;
        3'h7: begin
          nxt_rx_st = st_rx_data;
          nxt_rwl = rcnt_ff;
          nxt_rbyte = 2'h0;
          nxt_keep = 1'b0;
          nxt_ostrm = strm_c;
          nxt_rfirst = rsom_ff;
          if (is_str_c) begin
            if (rsom_ff) begin
              nxt_disc[idx_c] = 1'b0;
            end
            if (!drop_c) begin
              if (!reom_ff && rbc_ff == `SPWF_BC_ABORT) begin
                ab_ev = 1'b1;
              end else if ((!reom_ff && rbc_ff[1]) || (!reom_ff && rcnt_ff != 4'hf)) begin
                er_ev = 1'b1;
              end else if (newlen_c > maxsz_ff) begin
                tl_ev = 1'b1;
              end else begin
                nxt_keep = 1'b1;
                nxt_len[idx_c] = newlen_c;
              end
              if (ab_ev || er_ev || tl_ev) begin
                nxt_disc[idx_c] = 1'b1;
              end
              nxt_oab = ab_ev;
            end
          end
        end
        default: ;
      endcase
    end else if (lk_rx_vld) begin
      nxt_rbt = 3'h0;
      if (rx_st_ff == st_rx_data) begin
        nxt_rbyte = rbyte_ff + 2'h1;
        if (rbyte_ff != 2'h3) begin
          nxt_racc[{rbyte_ff, 3'b000} +: 8] = lk_rx_dat;
        end else begin
          // Whole words only; the last word carries its valid byte count minus one
          nxt_ovld = keep_ff;
          nxt_oword = {lk_rx_dat, racc_ff};
          nxt_ofst = rfirst_ff;
          nxt_rfirst = 1'b0;
          nxt_olst = reom_ff && (rwl_ff == 4'h0);
          nxt_onb = nxt_olst ? rbc_ff : 2'h3;
          nxt_rwl = rwl_ff - 4'h1;
          if (rwl_ff == 4'h0) begin
            nxt_rx_st = st_rx_hdr;
          end
        end
      end
    end
    // Counter clear by a write; a same-cycle event wins and the clear is lost
    nxt_abcnt = (reg_wr && reg_addr == `SPWF_OFS_ABCNT) ? 16'h0000 : abcnt_ff;
    nxt_tlcnt = (reg_wr && reg_addr == `SPWF_OFS_TLCNT) ? 16'h0000 : tlcnt_ff;
    nxt_ercnt = (reg_wr && reg_addr == `SPWF_OFS_ERCNT) ? 16'h0000 : ercnt_ff;
    if (ab_ev) nxt_abcnt = abcnt_ff + 16'h0001;
    if (tl_ev) nxt_tlcnt = tlcnt_ff + 16'h0001;
    if (er_ev) nxt_ercnt = ercnt_ff + 16'h0001;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_st_ff <= st_rx_hdr;
      rbt_ff <= 3'h0;
      rcmd_ff <= 6'h00;
      rcnt_ff <= 4'h0;
      rwl_ff <= 4'h0;
      {rsom_ff, reom_ff, rfmt_ff, rbc_ff, rbyte_ff} <= 7'h00;
      raddr_ff <= 24'h000000;
      racc_ff <= 24'h000000;
      keep_ff <= 1'b0;
      rfirst_ff <= 1'b0;
      disc_ff <= '0;
      len_ff <= '{default: 16'h0000};
      {ovld_ff, ofst_ff, olst_ff, oab_ff, onb_ff} <= 6'h00;
      oword_ff <= 32'h0000_0000;
      ostrm_ff <= 32'h0000_0000;
      abcnt_ff <= 16'h0000;
      tlcnt_ff <= 16'h0000;
      ercnt_ff <= 16'h0000;
    end else begin
      rx_st_ff <= nxt_rx_st;
      rbt_ff <= nxt_rbt;
      rcmd_ff <= nxt_rcmd;
      rcnt_ff <= nxt_rcnt;
      rwl_ff <= nxt_rwl;
      {rsom_ff, reom_ff, rfmt_ff, rbc_ff, rbyte_ff} <= {nxt_rsom, nxt_reom, nxt_rfmt, nxt_rbc, nxt_rbyte};
      raddr_ff <= nxt_raddr;
      racc_ff <= nxt_racc;
      keep_ff <= nxt_keep;
      rfirst_ff <= nxt_rfirst;
      disc_ff <= nxt_disc;
      len_ff <= nxt_len;
      {ovld_ff, ofst_ff, olst_ff, oab_ff, onb_ff} <= {nxt_ovld, nxt_ofst, nxt_olst, nxt_oab, nxt_onb};
      oword_ff <= nxt_oword;
      ostrm_ff <= nxt_ostrm;
      abcnt_ff <= nxt_abcnt;
      tlcnt_ff <= nxt_tlcnt;
      ercnt_ff <= nxt_ercnt;
    end
  end
  assign {rx_vld, rx_first, rx_last, rx_abort, rx_nbytes} = {ovld_ff, ofst_ff, olst_ff, oab_ff, onb_ff};
  assign rx_word = oword_ff;
  assign rx_stream = ostrm_ff;

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_hdr(logic [2:0] n);
    tx_st_ff == st_tx_hdr && bt_ff == n;
  endsequence
  sequence s_short_msg;
    tx_start && !tx_busy && !tx_abort && tx_len == 16'h0004;
  endsequence
  a_tx_cmd_field: assert property (s_hdr(3'h0) |=> lk_tx_ctl && lk_tx_dat[5:2] == `SPWF_CMD_PW)
    else $error("command field not posted write");
  a_tx_layout_bit: assert property (s_hdr(3'h3) |=> !lk_tx_dat[4])
    else $error("layout select bit set");
  a_tx_wcnt_ones: assert property (s_hdr(3'h3) && !last_c |=> lk_tx_dat[1:0] == 2'b11 && lk_tx_ctl)
    else $error("word count not all ones");
  a_tx_som_later: assert property (s_hdr(3'h3) && !first_ff |=> !lk_tx_dat[7])
    else $error("start flag on later segment");
  a_tx_bcount: assert property (s_hdr(3'h3) && fin_c |=> lk_tx_dat[3:2] == 2'($past(rem_ff) - 16'h0001))
    else $error("byte count wrong");
  a_tx_stream_hi: assert property (s_hdr(3'h7) |=> lk_tx_dat == strm_ff[31:24] ##1 !lk_tx_ctl)
    else $error("stream byte or data placement wrong");
  a_tx_one_seg: assert property (s_short_msg |-> ##1 tx_busy [*8] ##1 tx_busy [*4] ##1 !tx_busy)
    else $error("short message not one transaction");
  a_rx_drop_word: assert property (rx_st_ff == st_rx_data && !keep_ff |=> !rx_vld)
    else $error("dropped segment delivered");
  a_rx_abort_cnt: assert property (ab_ev |=> abcnt_ff == $past(abcnt_ff) + 16'h0001 && rx_abort)
    else $error("abort not counted");
  a_rx_toolong: assert property (tl_ev |=> tlcnt_ff == $past(tlcnt_ff) + 16'h0001 && !keep_ff)
    else $error("too long message not handled");
endmodule

/* verif/spwf_peer.sv */
// ****************************************
// Link partner: sources and sinks bit-times
// ****************************************
module spwf_peer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bit-times from the framer
  input wire logic lk_tx_vld,
  input wire logic lk_tx_ctl,
  input wire logic [7:0] lk_tx_dat,
  // Bit-times to the framer
  output logic lk_rx_vld,
  output logic lk_rx_ctl,
  output logic [7:0] lk_rx_dat
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] cap_q[$];
  initial begin
    lk_rx_vld = 1'b0;
    lk_rx_ctl = 1'b0;
    lk_rx_dat = 8'h00;
  end
  // Capture every emitted bit-time as {ctl, byte}
  always @(posedge clk) begin
    if (!rst && lk_tx_vld === 1'b1) begin
      cap_q.push_back({lk_tx_ctl, lk_tx_dat});
    end
  end
  // One bit-time per cycle, changed right after the edge
  task automatic put(input logic c, input logic [7:0] d);
    @(posedge clk);
    lk_rx_vld <= 1'b1;
    lk_rx_ctl <= c;
    lk_rx_dat <= d;
  endtask
  // Header then its payload, with no gap between them
  task automatic send_seg(input logic [5:0] cmd, input logic first_f, input logic last_f, input logic fmt,
                          input logic [1:0] bc, input logic [3:0] cnt, input logic [31:0] sid);
    put(1'b1, {2'b00, cmd});
    put(1'b1, 8'h00);
    put(1'b1, {cnt[1:0], 6'h00});
    put(1'b1, {first_f, last_f, 1'b0, fmt, bc, cnt[3:2]});
    for (int i = 0; i < 4; i++) begin
      put(1'b1, sid[8*i+:8]);
    end
    for (int i = 0; i < 4 * (cnt + 1); i++) begin
      put(1'b0, 8'ha0 + i[7:0]);
    end
    // Released bus shows no stale byte
    @(posedge clk);
    lk_rx_vld <= 1'b0;
    lk_rx_dat <= ~lk_rx_dat;
  endtask
endmodule

/* verif/tb_streaming_posted_write_framer.sv */
// ****************************************
// Self-checking bench
// ****************************************
module tb_streaming_posted_write_framer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] MAXM = 16'h1000;
  logic clk, rst, reg_wr, reg_rd, tx_start, tx_abort, tx_word_rd, tx_busy;
  logic [7:0] reg_addr, t;
  logic [31:0] reg_wdata, reg_rdata, tx_stream, tx_word, rx_word, rx_stream;
  logic [15:0] tx_len;
  logic lk_tx_vld, lk_tx_ctl, lk_rx_vld, lk_rx_ctl, rx_vld, rx_first, rx_last, rx_abort;
  logic [7:0] lk_tx_dat, lk_rx_dat;
  logic [1:0] rx_nbytes;
  logic [8:0] eq[$];
  logic [67:0] rx_q[$];
  int fail_count, cmp_count, ab_n, wk;

  spwf_framer #(.MAX_MSG(MAXM), .NSB(4)) u_spwf_framer (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_start(tx_start),
    .tx_abort(tx_abort), .tx_len(tx_len), .tx_stream(tx_stream), .tx_word(tx_word), .tx_word_rd(tx_word_rd),
    .tx_busy(tx_busy), .lk_tx_vld(lk_tx_vld), .lk_tx_ctl(lk_tx_ctl), .lk_tx_dat(lk_tx_dat),
    .lk_rx_vld(lk_rx_vld), .lk_rx_ctl(lk_rx_ctl), .lk_rx_dat(lk_rx_dat), .rx_vld(rx_vld), .rx_word(rx_word),
    .rx_stream(rx_stream), .rx_first(rx_first), .rx_last(rx_last), .rx_nbytes(rx_nbytes), .rx_abort(rx_abort));
  spwf_peer u_spwf_peer (.clk(clk), .rst(rst), .lk_tx_vld(lk_tx_vld), .lk_tx_ctl(lk_tx_ctl),
    .lk_tx_dat(lk_tx_dat), .lk_rx_vld(lk_rx_vld), .lk_rx_ctl(lk_rx_ctl), .lk_rx_dat(lk_rx_dat));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Message source: byte i of a message is 10h+i
  always @(posedge clk) begin
    if (tx_start) begin
      wk <= 0;
    end else if (tx_word_rd === 1'b1) begin
      t = 8'h10 + 8'(wk * 4);
      tx_word <= {t + 8'h3, t + 8'h2, t + 8'h1, t};
      wk <= wk + 1;
    end
  end
  // Collect delivered words and abort pulses
  always @(posedge clk) begin
    if (rx_vld === 1'b1) begin
      rx_q.push_back({rx_first, rx_last, rx_stream, rx_nbytes, rx_word});
    end
    if (rx_abort === 1'b1) begin
      ab_n++;
    end
  end

  task automatic chk(input logic [67:0] got, input logic [67:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e, "register read");
  endtask
  // Expected bit-times worked out segment by segment, then compared
  task automatic send_msg(input logic [15:0] len, input logic [31:0] sid, input logic ab,
                          input logic [1:0] cc, input logic [3:0] vc);
    int off, n, nw;
    logic last;
    logic [3:0] cnt;
    logic [1:0] bc;
    eq.delete();
    u_spwf_peer.cap_q.delete();
    off = 0;
    while (ab || off < len) begin
      n = (len - off > 64) ? 64 : len - off;
      last = ab || (off + 64 >= len);
      nw = ab ? 1 : (n + 3) / 4;
      cnt = last ? 4'(nw - 1) : 4'hf;
      bc = ab ? 2'h1 : last ? len[1:0] - 2'h1 : 2'h0;
      eq.push_back({1'b1, 2'b00, 4'hb, cc});
      eq.push_back({1'b1, 2'b00, vc[3], 5'h00});
      eq.push_back({1'b1, cnt[1:0], 3'h0, vc[2:0]});
      eq.push_back({1'b1, off == 0 && !ab, last && !ab, 2'b00, bc, cnt[3:2]});
      for (int i = 0; i < 4; i++) eq.push_back({1'b1, sid[8*i+:8]});
      for (int b = 0; b < nw * 4; b++) eq.push_back({1'b0, (!ab && off + b < len) ? 8'h10 + 8'(off + b) : 8'h00});
      if (ab) break;
      off += 64;
    end
    @(posedge clk);
    tx_start <= 1'b1;
    tx_len <= len;
    tx_stream <= sid;
    tx_abort <= ab;
    @(posedge clk);
    tx_start <= 1'b0;
    #1;
    for (n = 0; n < 600 && tx_busy !== 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
    if (n == 600) begin
      fail_count++;
      $display("[ERR] %0t transmit never finished", $time);
      tally_and_finish;
    end
    repeat (3) @(posedge clk);
    chk(u_spwf_peer.cap_q.size(), eq.size(), "bit-time count");
    for (int i = 0; i < eq.size() && i < u_spwf_peer.cap_q.size(); i++) begin
      chk(u_spwf_peer.cap_q[i], eq[i], "bit-time");
    end
  endtask

  // Main sequence
  initial begin
    {reg_wr, reg_rd, tx_start, tx_abort, reg_addr, reg_wdata, tx_len, tx_stream, tx_word} = '0;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rdc(8'h00, 32'h0);
    rdc(8'h08, 32'hffff_ff00);
    rdc(8'h0c, {16'h0, MAXM});
    rdc(8'h24, 32'h0);
    send_msg(16'd5, 32'h05, 1'b0, 2'h0, 4'h0);
    wr(8'h00, 32'h5b);
    send_msg(16'd68, 32'h0a06, 1'b0, 2'h3, 4'h5);
    send_msg(16'd16, 32'h07, 1'b1, 2'h3, 4'h5);
    send_msg(16'd4, 32'h09, 1'b0, 2'h3, 4'h5);
    u_spwf_peer.send_seg(6'h2c, 1'b1, 1'b1, 1'b0, 2'h1, 4'h0, 32'h05);
    u_spwf_peer.send_seg(6'h2c, 1'b1, 1'b0, 1'b0, 2'h1, 4'h0, 32'h06);
    u_spwf_peer.send_seg(6'h2c, 1'b0, 1'b1, 1'b0, 2'h3, 4'h0, 32'h06);
    u_spwf_peer.send_seg(6'h3c, 1'b1, 1'b1, 1'b0, 2'h3, 4'h0, 32'h05);
    u_spwf_peer.send_seg(6'h2c, 1'b1, 1'b1, 1'b1, 2'h3, 4'h0, 32'h05);
    u_spwf_peer.send_seg(6'h2c, 1'b1, 1'b1, 1'b0, 2'h3, 4'h0, 32'h105);
    wr(8'h0c, 32'h4);
    rdc(8'h0c, 32'h4);
    u_spwf_peer.send_seg(6'h2c, 1'b1, 1'b1, 1'b0, 2'h3, 4'h1, 32'h05);
    u_spwf_peer.send_seg(6'h2c, 1'b1, 1'b0, 1'b0, 2'h0, 4'h0, 32'h08);
    repeat (4) @(posedge clk);
    chk(rx_q.size(), 1, "delivered words");
    if (rx_q.size() > 0) chk(rx_q[0], {1'b1, 1'b1, 32'h05, 2'h1, 32'ha3a2_a1a0}, "delivered word");
    chk(ab_n, 1, "abort pulses");
    rdc(8'h10, 32'h1);
    rdc(8'h14, 32'h1);
    rdc(8'h18, 32'h1);
    rdc(8'h1c, 32'h0);
    wr(8'h10, 32'h0);
    rdc(8'h10, 32'h0);
    tally_and_finish;
  end
endmodule
